// file: rtl/pot_cmd_map.vh
/*
  Constants of the quad pot command decoder: slave address prefix,
  instruction opcodes, field positions, reset values and timing counts.
  Assumes a 125 MHz system clock.
*/
`ifndef POT_CMD_MAP_VH
`define POT_CMD_MAP_VH

// ----------------------------------------------------------------
// slave address
// ----------------------------------------------------------------
`define ADDR_PREFIX      4'h5
`define ADDR_PREFIX_MSB  7
`define ADDR_PREFIX_LSB  4

// ----------------------------------------------------------------
// instruction byte fields
// ----------------------------------------------------------------
`define OPC_MSB          7
`define OPC_LSB          4
`define POT_MSB          3
`define POT_LSB          2
`define SLOT_MSB         1
`define SLOT_LSB         0

`define OPC_RD_WIPER     4'h9
`define OPC_WR_WIPER     4'hA
`define OPC_RD_SAVED     4'hB
`define OPC_WR_SAVED     4'hC
`define OPC_RECALL_ONE   4'hD
`define OPC_STORE_ONE    4'hE
`define OPC_RECALL_ALL   4'h1
`define OPC_STORE_ALL    4'h8
`define OPC_STEP         4'h2

// ----------------------------------------------------------------
// wiper range and reset values
// ----------------------------------------------------------------
`define WIPER_MAX        6'h3F
`define WIPER_MIN        6'h00
`define SAVED_RESET      6'h00
`define SLOT_ZERO        2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS    8000
`define NV_WRITE_MS      5
`define NV_WRITE_CYCLES  ((`NV_WRITE_MS * 1000000) / (`CLK_PERIOD_PS / 1000))

`endif

// file: rtl/pot_sync.v
/*
  Two flip-flop synchroniser for pin inputs.
  Assumes the input is asynchronous to CLK.
*/
`timescale 1ns/1ps
module pot_sync
(
  input  wire clk,
  input  wire arst_n,
  input  wire din,
  output reg  dout
);
  reg meta;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pot_sync

// file: rtl/quad_pot_command_decoder.v
/*
  Serial command decoder of a quad 64-tap digital potentiometer: a
  two-wire bus slave that reads and writes the wiper positions and the
  saved settings, copies between them and steps a wiper.
  Assumes SCL and SDA arrive asynchronously and are sampled on CLK; the
  saved settings are flip-flops held busy for the programming time.
*/
`timescale 1ns/1ps
`include "pot_cmd_map.vh"
module quad_pot_command_decoder
#(
  parameter NV_CYCLES = `NV_WRITE_CYCLES
)
(
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        SCL,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE,
  input  wire [3:0]  ADDR_PINS,
  output reg  [23:0] WIPER_POSITIONS,
  output reg         NV_BUSY
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_INSN = 6'h04;
  localparam [5:0] ST_DATA = 6'h08;
  localparam [5:0] ST_READ = 6'h10;
  localparam [5:0] ST_STEP = 6'h20;

  // ----------------------------------------------------------------
  // pin sampling and bus events
  // ----------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  reg  scl_d;
  reg  sda_d;

  pot_sync u_sync_scl (.clk(CLK), .arst_n(ARST_N), .din(SCL), .dout(scl_s));
  pot_sync u_sync_sda (.clk(CLK), .arst_n(ARST_N), .din(SDA_IN), .dout(sda_s));

  // strap pins are sampled like any other pin
  wire [3:0] addr_s;
  genvar     g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_addr_sync
      pot_sync u_sync_addr (.clk(CLK), .arst_n(ARST_N), .din(ADDR_PINS[g]), .dout(addr_s[g]));
    end
  endgenerate

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [5:0]  wiper_position_reg [0:3];
  reg  [5:0]  saved_setting_reg  [0:15];
  reg  [5:0]  state;
  reg  [7:0]  shift;
  reg  [3:0]  bit_cnt;
  reg         ack_phase;
  reg         read_ack;
  reg  [7:0]  insn;
  reg  [7:0]  tx;
  reg         nv_pending;
  reg  [1:0]  nv_kind;
  reg  [5:0]  nv_data;
  reg  [31:0] nv_cnt;
  reg         power_up;
  reg  [2:0]  init_idx;
  integer     i;

  wire [3:0] opc  = insn[`OPC_MSB:`OPC_LSB];
  wire [1:0] pot  = insn[`POT_MSB:`POT_LSB];
  wire [1:0] slot = insn[`SLOT_MSB:`SLOT_LSB];
  wire [7:0] rx   = {shift[6:0], sda_s};
  wire       nv_op = (opc == `OPC_WR_SAVED) | (opc == `OPC_STORE_ONE) | (opc == `OPC_STORE_ALL);

  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      read_ack <= 1'b0;
      insn <= 8'h00;
      tx <= 8'h00;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      nv_pending <= 1'b0;
      nv_kind <= 2'h0;
      nv_data <= 6'h00;
      nv_cnt <= 32'h0;
      NV_BUSY <= 1'b0;
      power_up <= 1'b1;
      init_idx <= 3'h0;
      WIPER_POSITIONS <= 24'h000000;
      for (i = 0; i < 4; i = i + 1)
        wiper_position_reg[i] <= `WIPER_MIN;
      for (i = 0; i < 16; i = i + 1)
        saved_setting_reg[i] <= `SAVED_RESET;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      WIPER_POSITIONS <= {wiper_position_reg[3], wiper_position_reg[2],
                          wiper_position_reg[1], wiper_position_reg[0]};
      // ------------------------------------------------------------
      // power-up recall, then the programming timer
      // ------------------------------------------------------------
      if (power_up)
      begin
        wiper_position_reg[init_idx[1:0]] <= saved_setting_reg[{init_idx[1:0], `SLOT_ZERO}];
        init_idx <= init_idx + 3'h1;
        if (init_idx == 3'h3)
          power_up <= 1'b0;
      end
      if (NV_BUSY)
      begin
        if (nv_cnt >= NV_CYCLES - 1)
        begin
          NV_BUSY <= 1'b0;
          nv_cnt <= 32'h0;
          case (nv_kind)
            2'h0: saved_setting_reg[{pot, slot}] <= nv_data;
            2'h1: saved_setting_reg[{pot, slot}] <= wiper_position_reg[pot];
            default:
              for (i = 0; i < 4; i = i + 1)
                saved_setting_reg[{i[1:0], slot}] <= wiper_position_reg[i];
          endcase
        end
        else
          nv_cnt <= nv_cnt + 32'h1;
      end
      // ------------------------------------------------------------
      // bus slave
      // ------------------------------------------------------------
      if (start_ev)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        SDA_OE <= 1'b0;
        nv_pending <= 1'b0;
      end
      else if (stop_ev)
      begin
        state <= ST_IDLE;
        SDA_OE <= 1'b0;
        if (nv_pending && !NV_BUSY)
        begin
          NV_BUSY <= 1'b1;
          nv_pending <= 1'b0;
        end
        // the stop's own clock pulse has already counted one bit
        else if (!NV_BUSY && state == ST_DATA && bit_cnt == 4'h1 && !ack_phase)
        begin
          case (opc)
            `OPC_RECALL_ALL:
              for (i = 0; i < 4; i = i + 1)
                wiper_position_reg[i] <= saved_setting_reg[{i[1:0], slot}];
            `OPC_RECALL_ONE: wiper_position_reg[pot] <= saved_setting_reg[{pot, slot}];
            `OPC_STORE_ONE:
            begin
              nv_kind <= 2'h1;
              NV_BUSY <= 1'b1;
            end
            `OPC_STORE_ALL:
            begin
              nv_kind <= 2'h2;
              NV_BUSY <= 1'b1;
            end
            default: ;
          endcase
        end
      end
      else if (state == ST_STEP)
      begin
        // direction taken at the rise, step applied once the pulse ends
        if (scl_rise)
          shift <= rx;
        if (scl_fall && ack_phase)
        begin
          ack_phase <= 1'b0;
          SDA_OE <= 1'b0;
        end
        else if (scl_fall && shift[0] && wiper_position_reg[pot] != `WIPER_MAX)
          wiper_position_reg[pot] <= wiper_position_reg[pot] + 6'h01;
        else if (scl_fall && !shift[0] && wiper_position_reg[pot] != `WIPER_MIN)
          wiper_position_reg[pot] <= wiper_position_reg[pot] - 6'h01;
      end
      else if (state != ST_IDLE)
      begin
        if (scl_fall)
        begin
          if (ack_phase)
          begin
            ack_phase <= 1'b0;
            SDA_OE <= 1'b0;
            if (state == ST_READ)
            begin
              SDA_OE <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          end
          else if (bit_cnt == 4'h8)
          begin
            // read keeps the count so the master's ack bit ends the frame
            if (state == ST_READ)
              SDA_OE <= 1'b0;
            else
            begin
              bit_cnt <= 4'h0;
              ack_phase <= 1'b1;
              SDA_OE <= 1'b1;
            end
            case (state)
              ST_ADDR:
                if (shift[7:4] == `ADDR_PREFIX && shift[3:0] == addr_s && !NV_BUSY)
                  state <= ST_INSN;
                else
                begin
                  state <= ST_IDLE;
                  ack_phase <= 1'b0;
                  SDA_OE <= 1'b0;
                end
              ST_INSN:
              begin
                insn <= shift;
                if (shift[7:4] == `OPC_RD_WIPER || shift[7:4] == `OPC_RD_SAVED)
                begin
                  state <= ST_READ;
                  tx <= (shift[7:4] == `OPC_RD_WIPER) ?
                        {2'h0, wiper_position_reg[shift[3:2]]} :
                        {2'h0, saved_setting_reg[shift[3:0]]};
                end
                else if (shift[7:4] == `OPC_STEP)
                  state <= ST_STEP;
                else
                  state <= ST_DATA;
              end
              ST_DATA:
                if (opc == `OPC_WR_WIPER)
                  wiper_position_reg[pot] <= shift[5:0];
                else if (opc == `OPC_WR_SAVED)
                begin
                  nv_data <= shift[5:0];
                  nv_kind <= 2'h0;
                  nv_pending <= 1'b1;
                end
              default: ;
            endcase
          end
          else if (state == ST_READ && bit_cnt != 4'h0 && bit_cnt < 4'h8)
          begin
            SDA_OE <= ~tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end
        if (scl_rise && !ack_phase && !(state == ST_READ && bit_cnt == 4'h8))
        begin
          shift <= rx;
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (scl_rise && state == ST_READ && bit_cnt == 4'h8)
          state <= ST_IDLE;
      end
    end
  end
endmodule // quad_pot_command_decoder

// file: testbench/quad_pot_command_decoder_monitor.sv
/* port checker of the quad pot command decoder
   assumes bind to the top module, one clock domain */
`timescale 1ns/1ps
module quad_pot_command_decoder_monitor
#(
  parameter NV_CYCLES = 200
)
(
  input wire        CLK,
  input wire        ARST_N,
  input wire        SCL,
  input wire        SDA_IN,
  input wire        SDA_OUT,
  input wire        SDA_OE,
  input wire [3:0]  ADDR_PINS,
  input wire [23:0] WIPER_POSITIONS,
  input wire        NV_BUSY
);
  // ----------------------------------------
  // bus event, reset and busy counters
  // ----------------------------------------
  reg        psda;
  reg        pscl;
  reg [7:0]  since_stop;
  reg [7:0]  since_edge;
  reg [7:0]  since_rst;
  reg [19:0] busy_cnt;
  wire       stop_evt = SCL & pscl & SDA_IN & ~psda;
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      psda       <= 1'b1;
      pscl       <= 1'b1;
      since_stop <= 8'hFF;
      since_edge <= 8'h00;
      since_rst  <= 8'h00;
      busy_cnt   <= 20'h00000;
    end
    else
    begin
      psda       <= SDA_IN;
      pscl       <= SCL;
      since_stop <= stop_evt ? 8'h00 : since_stop + (since_stop != 8'hFF);
      since_edge <= (stop_evt | (SCL & ~pscl)) ? 8'h00 : since_edge + (since_edge != 8'hFF);
      since_rst  <= since_rst + (since_rst != 8'hFF);
      busy_cnt   <= NV_BUSY ? busy_cnt + 20'h00001 : 20'h00000;
    end
  end
  property p_od; @(posedge CLK) disable iff (!ARST_N) SDA_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_nv_stop; @(posedge CLK) disable iff (!ARST_N) $rose(NV_BUSY) |-> since_stop < 8'h08; endproperty
  a_nv_stop: assert property (p_nv_stop) else $error("programming not at stop");
  property p_nv_len;
    @(posedge CLK) disable iff (!ARST_N) $fell(NV_BUSY) |-> busy_cnt + 2 >= NV_CYCLES && busy_cnt <= NV_CYCLES + 2;
  endproperty
  a_nv_len: assert property (p_nv_len) else $error("programming time wrong");
  property p_nv_hold; @(posedge CLK) disable iff (!ARST_N) $rose(NV_BUSY) |=> NV_BUSY [*8]; endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("busy too short");
  property p_oe_low; @(posedge CLK) disable iff (!ARST_N) $changed(SDA_OE) |-> !SCL; endproperty
  a_oe_low: assert property (p_oe_low) else $error("sda changed with scl high");
  property p_frozen; @(posedge CLK) disable iff (!ARST_N) NV_BUSY && $past(NV_BUSY) |-> $stable(WIPER_POSITIONS); endproperty
  a_frozen: assert property (p_frozen) else $error("wiper moved while busy");
  property p_rst; @(posedge CLK) disable iff (!ARST_N) since_rst < 8'h10 |-> WIPER_POSITIONS == 24'h000000; endproperty
  a_rst: assert property (p_rst) else $error("wipers not slot zero");
  property p_idle; @(posedge CLK) disable iff (!ARST_N) $changed(WIPER_POSITIONS) |-> since_edge < 8'h10; endproperty
  a_idle: assert property (p_idle) else $error("wiper moved on idle bus");
endmodule // quad_pot_command_decoder_monitor
bind quad_pot_command_decoder quad_pot_command_decoder_monitor #(.NV_CYCLES(NV_CYCLES)) mon
  (.CLK(CLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .ADDR_PINS(ADDR_PINS), .WIPER_POSITIONS(WIPER_POSITIONS), .NV_BUSY(NV_BUSY));

// file: testbench/pot_bus_master.sv
/* two-wire bus master model, 80 ns bit time
   assumes sda is resolved outside with a pull-up */
`timescale 1ns/1ps
module pot_bus_master
(
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task t(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  // data moves only while scl low
  task bit_io(input b, output r);
  begin
    sda_low = ~b;
    t(2);
    scl = 1'b1;
    t(4);
    r = sda;
    t(1);
    scl = 1'b0;
    t(3);
  end
  endtask
  task start;
  begin
    sda_low = 1'b1;
    t(4);
    scl = 1'b0;
    t(3);
  end
  endtask
  task stop;
  begin
    sda_low = 1'b1;
    t(2);
    scl = 1'b1;
    t(4);
    sda_low = 1'b0;
    t(8);
  end
  endtask
  // msb first, ninth bit acknowledge
  task xfer(input [7:0] d, output [7:0] q, output ack);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(1'b1, r);
    ack = ~r;
  end
  endtask
endmodule // pot_bus_master

// file: testbench/quad_pot_command_decoder_tb.sv
/* self-checking bench of the quad pot command decoder
   assumes the bus master model and the bound checker */
`timescale 1ns/1ps
`include "pot_cmd_map.vh"
`define CHK(a, b) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin fails = fails + 1; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module quad_pot_command_decoder_tb;
  localparam NV = 200;
  reg         clk;
  reg         arst_n;
  reg  [3:0]  pins;
  reg  [7:0]  q;
  wire        scl;
  wire        m_low;
  wire        sda_out;
  wire        sda_oe;
  wire        busy;
  wire [23:0] wp;
  wire [7:0]  ad = {`ADDR_PREFIX, pins};
  wire        sda = ~(m_low | (sda_oe & ~sda_out));
  integer     fails;
  integer     samples_checked;
  quad_pot_command_decoder #(.NV_CYCLES(NV)) dut (.CLK(clk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_PINS(pins), .WIPER_POSITIONS(wp), .NV_BUSY(busy));
  pot_bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
  always #4 clk = ~clk;
  task stop_test;
  begin
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  function [7:0] ib(input [3:0] o, input [1:0] p, input [1:0] s);
    ib = {o, p, s};
  endfunction
  // n: 2 two-byte, 3 write, 4 read, 5 step bits
  task frame(input [7:0] a, input [7:0] ins, input integer n, input [7:0] d, input e);
    integer i;
    reg     k;
    reg     r;
  begin
    m.start;
    m.xfer(a, q, k);
    `CHK(k, e)
    if (e)
    begin
      m.xfer(ins, q, k);
      `CHK(k, 1'b1)
      if (n == 3 || n == 4)
        m.xfer(d, q, k);
      if (n == 3)
        `CHK(k, 1'b1)
      for (i = 7; n == 5 && i >= 0; i = i - 1)
        m.bit_io(d[i], r);
    end
    m.stop;
  end
  endtask
  task nvwait;
  begin
    `CHK(busy, 1'b1)
    repeat (NV + 8) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
  end
  endtask
  initial
  begin
    #300000;
    fails = fails + 1;
    stop_test;
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    pins = 4'hA;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    `CHK(wp, 24'h000000)
    frame(ad, ib(`OPC_WR_WIPER, 2'h2, 2'h0), 3, 8'h2A, 1'b1);
    `CHK(wp[17:12], 6'h2A)
    frame(ad, ib(`OPC_RD_WIPER, 2'h2, 2'h0), 4, 8'hFF, 1'b1);
    `CHK(q, 8'h2A)
    frame(ad, ib(`OPC_STORE_ONE, 2'h2, 2'h1), 2, 8'h00, 1'b1);
    frame(ad, ib(`OPC_RD_WIPER, 2'h2, 2'h0), 2, 8'h00, 1'b0);
    nvwait;
    frame(ad, ib(`OPC_WR_WIPER, 2'h2, 2'h0), 3, 8'h05, 1'b1);
    frame(ad, ib(`OPC_RECALL_ONE, 2'h2, 2'h1), 2, 8'h00, 1'b1);
    `CHK(wp[17:12], 6'h2A)
    frame(ad, ib(`OPC_WR_SAVED, 2'h1, 2'h3), 3, 8'hFF, 1'b1);
    nvwait;
    frame(ad, ib(`OPC_RD_SAVED, 2'h1, 2'h3), 4, 8'hFF, 1'b1);
    `CHK(q, 8'h3F)
    frame(ad, ib(`OPC_WR_WIPER, 2'h3, 2'h0), 3, 8'h11, 1'b1);
    frame(ad, ib(`OPC_STORE_ALL, 2'h0, 2'h2), 2, 8'h00, 1'b1);
    nvwait;
    frame(ad, ib(`OPC_RD_SAVED, 2'h3, 2'h2), 4, 8'hFF, 1'b1);
    `CHK(q, 8'h11)
    frame(ad, ib(`OPC_RD_SAVED, 2'h2, 2'h2), 4, 8'hFF, 1'b1);
    `CHK(q, 8'h2A)
    frame(ad, ib(`OPC_RECALL_ALL, 2'h0, 2'h3), 2, 8'h00, 1'b1);
    `CHK(wp, {6'h00, 6'h00, 6'h3F, 6'h00})
    frame(ad, ib(`OPC_STEP, 2'h1, 2'h0), 5, 8'hC0, 1'b1);
    `CHK(wp[11:6], 6'h39)
    frame(ad, ib(`OPC_STEP, 2'h0, 2'h0), 5, 8'h0F, 1'b1);
    `CHK(wp[5:0], 6'h04)
    frame({`ADDR_PREFIX, ~pins}, ib(`OPC_WR_WIPER, 2'h0, 2'h0), 3, 8'h00, 1'b0);
    `CHK(wp[5:0], 6'h04)
    stop_test;
  end
endmodule // quad_pot_command_decoder_tb
